// ===== design/cpci_pkg.sv
// Purpose: constants for the coolant pump control interface
// Assumes: 10 MHz clk
// Notes: register map and timing counts
package cpci_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_SWAP_LEN = 4'h4;
  localparam logic [3:0] ADDR_FAIL_TIME = 4'h5;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SWAP_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_LEAK_TEST_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  localparam int IRQ_LEAK_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam int IRQ_SEL_BIT = 2;
  localparam int IRQ_FAIL_BIT = 3;
  localparam int IRQ_SWAP_DONE_BIT = 4;
  localparam int IRQ_W = 5;
  localparam logic [15:0] SWAP_LEN_RESET = 16'h03E8;
  localparam int unsigned FAIL_TIME_MS = 5000;
  localparam int unsigned FAIL_TIME_CYC = FAIL_TIME_MS * (CLK_HZ / 1000);
  localparam logic [31:0] FAIL_TIME_RESET = 32'(FAIL_TIME_CYC);
  typedef enum logic [1:0] {
    CPCI_IDLE = 2'b00,
    CPCI_PULSE = 2'b01,
    CPCI_WAIT = 2'b10
  } cpci_swap_t;
endpackage : cpci_pkg

// ===== design/cpci_sync.sv
// Purpose: two-flop synchroniser per bit
// Assumes: asynchronous inputs
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module cpci_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      always_ff @(posedge clk) begin
        if (reset) begin
          s1_ff <= INIT[i];
          s2_ff <= INIT[i];
        end else begin
          s1_ff <= d[i];
          s2_ff <= s1_ff;
        end
      end
      assign q[i] = s2_ff;
    end
  endgenerate
endmodule : cpci_sync

// ===== design/cpci_top.sv
// Purpose: coolant pump control interface of the transmitter controller
// Assumes: 10 MHz clk, synchronous reset, pull-ups on panel inputs
// Notes: register port with read data one cycle later
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
module cpci_top #(
  parameter logic [31:0] FAIL_TIME_DEF = cpci_pkg::FAIL_TIME_RESET
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tx_leak_in,
  input wire logic pa_leak_in,
  input wire logic flow_ok_in,
  input wire logic pump_a_sel_n,
  input wire logic pump_b_sel_n,
  input wire logic remote_mode_in,
  output logic coolant_leak_interlock,
  output logic rf_mute,
  output logic pump_run,
  output logic pump_swap,
  output logic irq
);
  logic [5:0] raw;
  logic [5:0] syn;
  logic leak;
  logic flow_ok;
  logic sel_a;
  logic sel_b;
  logic remote;
  logic [3:0] ctrl_ff;
  logic [15:0] swap_len_ff;
  logic [31:0] fail_time_ff;
  logic [cpci_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [cpci_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [cpci_pkg::IRQ_W-1:0] ev;
  logic [31:0] rdata_ff;
  logic [31:0] fail_cnt_ff;
  logic [15:0] pulse_cnt_ff;
  cpci_pkg::cpci_swap_t state_ff;
  logic sel_at_swap_ff;
  logic leak_ff;
  logic remote_ff;
  logic sel_ff;
  logic run_ff;
  logic swap_ff;
  logic mute_ff;
  logic intlk_ff;
  logic wr_ctrl;
  logic swap_req;
  logic fail_hit;
  logic swap_done;

  assign raw = {remote_mode_in, pump_b_sel_n, pump_a_sel_n, flow_ok_in, pa_leak_in, tx_leak_in};
  cpci_sync #(.W(6), .INIT(6'h3C)) u_sync (
    .clk(clk),
    .reset(reset),
    .d(raw),
    .q(syn)
  );
  assign leak = syn[0] | syn[1] | ctrl_ff[cpci_pkg::CTRL_LEAK_TEST_BIT];
  assign flow_ok = syn[2];
  assign sel_a = ~syn[3];
  assign sel_b = ~syn[4];
  assign remote = syn[5];

  assign wr_ctrl = reg_wr && (reg_addr == cpci_pkg::ADDR_CTRL);

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= cpci_pkg::CTRL_RESET;
      swap_len_ff <= cpci_pkg::SWAP_LEN_RESET;
      fail_time_ff <= FAIL_TIME_DEF;
      irq_mask_ff <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        cpci_pkg::ADDR_CTRL: begin
          ctrl_ff <= reg_wdata[3:0] & 4'hD;
        end
        cpci_pkg::ADDR_SWAP_LEN: begin
          swap_len_ff <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
        end
        cpci_pkg::ADDR_FAIL_TIME: begin
          fail_time_ff <= reg_wdata;
        end
        cpci_pkg::ADDR_IRQ_MASK: begin
          irq_mask_ff <= reg_wdata[cpci_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // failover on flow loss in remote mode
  // restart timer during a swap
  always_ff @(posedge clk) begin
    if (reset || !remote || !run_ff || flow_ok || leak
        || (state_ff != cpci_pkg::CPCI_IDLE)) begin
      fail_cnt_ff <= '0;
    end else if (fail_cnt_ff < fail_time_ff) begin
      fail_cnt_ff <= fail_cnt_ff + 32'h00000001;
    end
  end
  assign fail_hit = (fail_cnt_ff == fail_time_ff) && (fail_time_ff != 32'h00000000)
                    && remote && run_ff && !flow_ok && !leak;

  assign swap_req = (wr_ctrl && reg_wdata[cpci_pkg::CTRL_SWAP_BIT])
                    || (fail_hit && ctrl_ff[cpci_pkg::CTRL_AUTO_BIT] && state_ff == cpci_pkg::CPCI_IDLE);

  // pulse of swap_len_ff cycles then wait for selection change
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= cpci_pkg::CPCI_IDLE;
      pulse_cnt_ff <= '0;
      sel_at_swap_ff <= 1'b0;
      swap_ff <= 1'b0;
    end else begin
      case (state_ff)
        cpci_pkg::CPCI_IDLE: begin
          if (swap_req && remote && !leak) begin
            state_ff <= cpci_pkg::CPCI_PULSE;
            pulse_cnt_ff <= swap_len_ff;
            sel_at_swap_ff <= sel_a;
            swap_ff <= 1'b1;
          end
        end
        cpci_pkg::CPCI_PULSE: begin
          if (pulse_cnt_ff == 16'h0001) begin
            swap_ff <= 1'b0;
            state_ff <= cpci_pkg::CPCI_WAIT;
          end else begin
            pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
          end
        end
        cpci_pkg::CPCI_WAIT: begin
          if ((sel_a != sel_at_swap_ff) || !remote) begin
            state_ff <= cpci_pkg::CPCI_IDLE;
          end
        end
        default: begin
          state_ff <= cpci_pkg::CPCI_IDLE;
          swap_ff <= 1'b0;
        end
      endcase
    end
  end
  assign swap_done = (state_ff == cpci_pkg::CPCI_WAIT) && (sel_a != sel_at_swap_ff);

  // mute and pumps off on leak
  always_ff @(posedge clk) begin
    if (reset) begin
      intlk_ff <= 1'b0;
      mute_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      intlk_ff <= leak;
      mute_ff <= leak;
      run_ff <= ctrl_ff[cpci_pkg::CTRL_RUN_BIT] && !leak && remote;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      leak_ff <= 1'b0;
      remote_ff <= 1'b1;
      sel_ff <= 1'b0;
    end else begin
      leak_ff <= leak;
      remote_ff <= remote;
      sel_ff <= sel_a;
    end
  end
  always_comb begin
    ev = '0;
    ev[cpci_pkg::IRQ_LEAK_BIT] = leak && !leak_ff;
    ev[cpci_pkg::IRQ_MODE_BIT] = remote != remote_ff;
    ev[cpci_pkg::IRQ_SEL_BIT] = sel_a != sel_ff;
    ev[cpci_pkg::IRQ_FAIL_BIT] = fail_hit && (fail_cnt_ff != 32'h00000000) && !leak_ff && 1'b1
                                 && (state_ff == cpci_pkg::CPCI_IDLE);
    ev[cpci_pkg::IRQ_SWAP_DONE_BIT] = swap_done;
  end

  // set wins over write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_ff <= '0;
    end else if (reg_wr && reg_addr == cpci_pkg::ADDR_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[cpci_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        cpci_pkg::ADDR_CTRL: rdata_ff <= {28'h0000000, ctrl_ff};
        cpci_pkg::ADDR_STAT: rdata_ff <= {23'h000000, state_ff, swap_ff, run_ff, intlk_ff,
                                          remote, sel_b, sel_a, flow_ok};
        cpci_pkg::ADDR_IRQ_STAT: rdata_ff <= {27'h0000000, irq_stat_ff};
        cpci_pkg::ADDR_IRQ_MASK: rdata_ff <= {27'h0000000, irq_mask_ff};
        cpci_pkg::ADDR_SWAP_LEN: rdata_ff <= {16'h0000, swap_len_ff};
        cpci_pkg::ADDR_FAIL_TIME: rdata_ff <= fail_time_ff;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign coolant_leak_interlock = intlk_ff;
  assign rf_mute = mute_ff;
  assign pump_run = run_ff;
  assign pump_swap = swap_ff;
endmodule : cpci_top

// ===== verif/cpci_assertions.sv
// Purpose: port checks for cpci_top
// Assumes: swap length of 2 or more
// Notes: bound to cpci_top below
`timescale 1ns/10ps
module cpci_chk #(
  parameter logic [31:0] FAIL_TIME_DEF = 32'h14
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_leak_in,
  input wire logic pa_leak_in,
  input wire logic remote_mode_in,
  input wire logic coolant_leak_interlock,
  input wire logic rf_mute,
  input wire logic pump_run,
  input wire logic pump_swap,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_mute_tracks_lock: assert property (rf_mute == coolant_leak_interlock)
    else $error("mute differs from interlock");
  a_lock_stops_run: assert property (coolant_leak_interlock |-> !pump_run)
    else $error("pump runs during leak");
  a_leak_sets_lock: assert property (
    (tx_leak_in || pa_leak_in) [*3] |=> coolant_leak_interlock)
    else $error("leak not seen");
  a_local_stops_run: assert property (!remote_mode_in [*3] |=> !pump_run)
    else $error("pump runs in local");
  a_swap_not_leak: assert property ($rose(pump_swap) |-> !coolant_leak_interlock)
    else $error("swap during leak");
  a_swap_held: assert property ($rose(pump_swap) |=> pump_swap)
    else $error("swap pulse too short");
  a_swap_single: assert property ($fell(pump_swap) |=> !pump_swap)
    else $error("swap pulse repeated");
  a_reset_quiet: assert property (
    $fell(reset) |-> !(pump_run || pump_swap || irq || rf_mute))
    else $error("outputs not idle after reset");
endmodule : cpci_chk
bind cpci_top cpci_chk #(.FAIL_TIME_DEF(FAIL_TIME_DEF)) cpci_chk_i (
  .clk(clk),
  .reset(reset),
  .tx_leak_in(tx_leak_in),
  .pa_leak_in(pa_leak_in),
  .remote_mode_in(remote_mode_in),
  .coolant_leak_interlock(coolant_leak_interlock),
  .rf_mute(rf_mute),
  .pump_run(pump_run),
  .pump_swap(pump_swap),
  .irq(irq)
);

// ===== verif/cpci_panel_model.sv
// Purpose: cooling panel and pump controller model
// Assumes: bench sets selector and flow faults
// Notes: flow loss time shortened
`timescale 1ns/10ps
module cpci_panel_model #(
  parameter int LOSS_CYC = 50
) (
  input wire logic clk,
  input wire logic coolant_leak_interlock,
  input wire logic pump_run,
  input wire logic pump_swap,
  input wire logic remote_sel,
  input wire logic flow_fault,
  output logic pump_a_sel_n,
  output logic pump_b_sel_n,
  output logic remote_mode_in,
  output logic flow_ok_in
);
  logic use_b_ff = 1'b0, swap_d_ff = 1'b0, run;
  int loss_ff = 0;
  assign run = !coolant_leak_interlock && (pump_run || !remote_sel);
  assign flow_ok_in = run && !flow_fault;
  assign remote_mode_in = remote_sel;
  assign pump_a_sel_n = use_b_ff;
  assign pump_b_sel_n = !use_b_ff;
  always @(posedge clk) begin
    swap_d_ff <= pump_swap;
    loss_ff <= (run && flow_fault) ? loss_ff + 1 : 0;
    if ((remote_sel && swap_d_ff && !pump_swap) || loss_ff == LOSS_CYC)
      use_b_ff <= !use_b_ff;
  end
endmodule : cpci_panel_model

// ===== verif/cpci_tb_top.sv
// Purpose: bench for cpci_top
// Assumes: panel model on the far side
// Notes: failover time cut to 20 cycles
`timescale 1ns/10ps
module cpci_tb_top;
  logic clk = 1'b0, flow_ok_in, pump_a_sel_n, pump_b_sel_n, remote_mode_in, irq;
  logic coolant_leak_interlock, rf_mute, pump_run, pump_swap, remote_sel = 1'b1;
  logic reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_leak_in = 1'b0, pa_leak_in = 1'b0;
  logic flow_fault = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int fails = 0, checks_done = 0, swap_hi = 0;
  // tx pa remote leak_test run, then interlock and run
  logic [6:0] rows [6] = '{7'h15, 7'h10, 7'h04, 7'h56, 7'h26, 7'h1E};
  cpci_top #(.FAIL_TIME_DEF(32'h14)) cpci_top_i (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .tx_leak_in(tx_leak_in),
    .pa_leak_in(pa_leak_in),
    .flow_ok_in(flow_ok_in),
    .pump_a_sel_n(pump_a_sel_n),
    .pump_b_sel_n(pump_b_sel_n),
    .remote_mode_in(remote_mode_in),
    .coolant_leak_interlock(coolant_leak_interlock),
    .rf_mute(rf_mute),
    .pump_run(pump_run),
    .pump_swap(pump_swap),
    .irq(irq)
  );
  cpci_panel_model cpci_panel_model_i (
    .clk(clk),
    .coolant_leak_interlock(coolant_leak_interlock),
    .pump_run(pump_run),
    .pump_swap(pump_swap),
    .remote_sel(remote_sel),
    .flow_fault(flow_fault),
    .pump_a_sel_n(pump_a_sel_n),
    .pump_b_sel_n(pump_b_sel_n),
    .remote_mode_in(remote_mode_in),
    .flow_ok_in(flow_ok_in)
  );
  initial forever #50 clk = ~clk;
  always @(posedge clk) swap_hi += int'(pump_swap === 1'b1);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task automatic see(ref logic s, input logic e);
    #1;
    check(32'(s), 32'(e));
    @(posedge clk);
  endtask : see
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd} <= {w, !w};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
    if (!w)
      check(reg_rdata, d);
    @(posedge clk);
  endtask : bus
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      {tx_leak_in, pa_leak_in, remote_sel} <= rows[i][6:4];
      bus(1'b1, cpci_pkg::ADDR_CTRL, {28'h0, rows[i][3], 2'b10, rows[i][2]});
      repeat (6) @(posedge clk);
      see(coolant_leak_interlock, rows[i][1]);
      see(rf_mute, rows[i][1]);
      see(pump_run, rows[i][0]);
    end
    $display("table done");
    bus(1'b1, cpci_pkg::ADDR_SWAP_LEN, 32'h3);
    bus(1'b1, cpci_pkg::ADDR_IRQ_MASK, 32'h10);
    swap_hi = 0;
    // first write lifts leak test, last two land in pulse and wait
    repeat (4) bus(1'b1, cpci_pkg::ADDR_CTRL, 32'h7);
    repeat (30) @(posedge clk);
    see(irq, 1'b1);
    bus(1'b0, cpci_pkg::ADDR_STAT, 32'h2D);
    check(32'(swap_hi), 32'h3);
    bus(1'b1, cpci_pkg::ADDR_IRQ_MASK, 32'h0);
    see(irq, 1'b0);
    bus(1'b1, cpci_pkg::ADDR_IRQ_STAT, 32'h10);
    bus(1'b1, cpci_pkg::ADDR_IRQ_MASK, 32'h10);
    see(irq, 1'b0);
    $display("swap and irq done");
    remote_sel <= 1'b0;
    repeat (4) @(posedge clk);
    swap_hi = 0;
    bus(1'b1, cpci_pkg::ADDR_CTRL, 32'h7);
    repeat (20) @(posedge clk);
    check(32'(swap_hi), 32'h0);
    remote_sel <= 1'b1;
    flow_fault <= 1'b1;
    repeat (40) @(posedge clk);
    check(32'(swap_hi), 32'h3);
    see(pump_run, 1'b1);
    flow_fault <= 1'b0;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    see(pump_run, 1'b0);
    bus(1'b0, cpci_pkg::ADDR_CTRL, 32'(cpci_pkg::CTRL_RESET));
    bus(1'b0, cpci_pkg::ADDR_SWAP_LEN, 32'(cpci_pkg::SWAP_LEN_RESET));
    bus(1'b0, 4'hF, 32'h0);
    $display("failover and reset done");
    tally_and_finish();
  end
endmodule : cpci_tb_top
